// ===== hw/adcrf_pkg.sv
package adcrf_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is index times four)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL_A = 8'h00;
    localparam logic [7:0] IDX_CTRL_B = 8'h01;
    localparam logic [7:0] IDX_REFCTL = 8'h02;
    localparam logic [7:0] IDX_EVCTL = 8'h03;
    localparam logic [7:0] IDX_CLKDIV = 8'h04;
    localparam logic [7:0] IDX_FLAGS = 8'h06;
    localparam logic [7:0] IDX_SCRATCH = 8'h07;
    localparam logic [7:0] IDX_SAMPLE = 8'h08;
    localparam logic [7:0] IDX_CAL_LO = 8'h0c;
    localparam logic [7:0] IDX_MIR_LO = 8'h10;
    localparam logic [7:0] IDX_MIR_HI = 8'h11;
    localparam logic [7:0] IDX_CMP_LO = 8'h18;
    localparam logic [7:0] IDX_CMP_HI = 8'h19;
    localparam logic [7:0] IDX_CH_BASE = 8'h20;
    localparam logic [7:0] IDX_CH_CTRL = 8'h20;
    localparam logic [7:0] IDX_CH_MUX = 8'h21;
    localparam logic [7:0] IDX_CH_INTCTL = 8'h22;
    localparam logic [7:0] IDX_CH_FLAGS = 8'h23;
    localparam logic [7:0] IDX_CH_RES_LO = 8'h24;
    localparam logic [7:0] IDX_CH_RES_HI = 8'h25;
    localparam logic [7:0] IDX_CH_SCAN = 8'h26;
    // ------------------------------------------------------------
    // field positions and codes
    // ------------------------------------------------------------
    localparam int GO_BIT = 2;
    localparam int ENABLE_BIT = 0;
    localparam int SIGNED_BIT = 4;
    localparam int CONTINUOUS_CONVERSION_BIT = 3;
    localparam int RES_LSB = 1;
    localparam int DIFF_BIT = 1;
    localparam int POSITIVE_INPUT_SELECT_LSB = 3;
    localparam int OFFSET_LSB = 4;
    localparam int COUNT_LSB = 0;
    localparam int FLAG_BIT = 0;
    localparam logic [1:0] RES_12_RIGHT = 2'h0;
    localparam logic [1:0] RES_8 = 2'h1;
    localparam logic [1:0] RES_12_LEFT = 2'h2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] LOW_PAD = 4'h0;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [9:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } adcrf_avs_req_s;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] refctl;
        logic [7:0] evctl;
        logic [7:0] clkdiv;
        logic [7:0] scratch;
        logic [7:0] sample;
        logic [7:0] cal_lo;
        logic [7:0] cmp_lo;
        logic [7:0] cmp_hi;
        logic [7:0] ch_ctrl;
        logic [7:0] ch_mux;
        logic [7:0] ch_intctl;
        logic flag;
        logic [15:0] result;
        logic [3:0] scan_offset;
        logic [3:0] scan_count;
        logic [3:0] pos_applied;
        logic waitreq;
        logic [31:0] rdata;
        logic start;
    } adcrf_state_s;
endpackage

// ===== hw/adcrf_core.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - signed results appear in two's complement, msb is the sign, except 12-bit right adjusted without differential input (msb zero).
// - low and high result bytes form one 16-bit value, read low first.
// - 12-bit left adjusted: high byte holds result bits 11..4.
// - 12-bit left adjusted: low byte bits 7..4 hold result 3..0.
// - 12-bit right adjusted: high byte bits 3..0 hold result 11..8.
// - 12-bit right: high bits 7..4 sign-extend when signed and differential, else zero.
// - 8-bit: high byte sign-extends bit 7 when signed, else zero.
// - right adjusted and 8-bit: low byte holds bits 7..0, read-only, resets zero.
// - scanning runs only while scan length is nonzero.
// - applied positive input equals selector plus scan offset while scanning, else the selector.
// - offset increments after each conversion while not equal to scan length.
// - offset equal to length clears to zero on the next conversion.
// - a scan covers length plus one inputs from selector plus offset.
// - positive selector is bits 6..3 of the channel mux register.
// - flag sets on each conversion, clears by vector service or writing one.
module adcrf_core
    import adcrf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire adcrf_pkg::adcrf_avs_req_s i_avs,
    output logic o_waitrequest,
    output logic [31:0] o_readdata,
    input wire logic i_conv_done,
    input wire logic [11:0] i_conv_raw,
    input wire logic i_vector_ack,
    output logic [3:0] o_pos_input,
    output logic o_conv_start,
    output logic o_flag
);
    import adcrf_pkg::*;

    adcrf_state_s state;
    adcrf_state_s next_state;

    // ------------------------------------------------------------
    // result formatting
    // ------------------------------------------------------------
    function automatic logic [15:0] fmt_result(input logic [11:0] raw,
                                               input logic [1:0] res,
                                               input logic sgn,
                                               input logic diff);
        logic [15:0] val;
        val = {4'h0, raw};
        if (res == RES_12_LEFT) begin
            val = {raw, LOW_PAD};
        end else if (res == RES_8) begin
            val = {(sgn ? {8{raw[7]}} : 8'h00), raw[7:0]};
        end else begin
            val = {((sgn && diff) ? {4{raw[11]}} : 4'h0), raw};
        end
        return val;
    endfunction

    logic [7:0] idx;
    logic take;
    logic wr_en;
    logic [7:0] wbyte;
    logic [1:0] res_mode;
    logic sgn_mode;
    logic diff_mode;
    logic scan_on;
    logic [3:0] mux_pos;

    assign idx = i_avs.address[9:2];
    assign take = (i_avs.read || i_avs.write) && !state.waitreq;
    assign wr_en = take && i_avs.write && i_avs.byteenable[0];
    assign wbyte = i_avs.writedata[7:0];
    assign res_mode = state.ctrl_b[RES_LSB +: 2];
    assign sgn_mode = state.ctrl_b[SIGNED_BIT];
    assign diff_mode = state.ch_ctrl[DIFF_BIT];
    assign scan_on = (state.scan_count != 4'h0);
    assign mux_pos = state.ch_mux[POSITIVE_INPUT_SELECT_LSB +: 4];

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    function automatic logic [7:0] read_byte(input adcrf_state_s s, input logic [7:0] a);
        logic [7:0] v;
        v = RESET_BYTE;
        if (a == IDX_CTRL_A) begin
            v = s.ctrl_a;
        end else if (a == IDX_CTRL_B) begin
            v = s.ctrl_b;
        end else if (a == IDX_REFCTL) begin
            v = s.refctl;
        end else if (a == IDX_EVCTL) begin
            v = s.evctl;
        end else if (a == IDX_CLKDIV) begin
            v = s.clkdiv;
        end else if (a == IDX_FLAGS || a == IDX_CH_FLAGS) begin
            v = {7'h00, s.flag};
        end else if (a == IDX_SCRATCH) begin
            v = s.scratch;
        end else if (a == IDX_SAMPLE) begin
            v = s.sample;
        end else if (a == IDX_CAL_LO) begin
            v = s.cal_lo;
        end else if (a == IDX_MIR_LO || a == IDX_CH_RES_LO) begin
            v = s.result[7:0];
        end else if (a == IDX_MIR_HI || a == IDX_CH_RES_HI) begin
            v = s.scratch;
        end else if (a == IDX_CMP_LO) begin
            v = s.cmp_lo;
        end else if (a == IDX_CMP_HI) begin
            v = s.cmp_hi;
        end else if (a == IDX_CH_CTRL) begin
            v = s.ch_ctrl;
        end else if (a == IDX_CH_MUX) begin
            v = s.ch_mux;
        end else if (a == IDX_CH_INTCTL) begin
            v = s.ch_intctl;
        end else if (a == IDX_CH_SCAN) begin
            v = {s.scan_offset, s.scan_count};
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.start = 1'b0;
        // one wait cycle, then the request is answered
        next_state.waitreq = !((i_avs.read || i_avs.write) && state.waitreq);
        if ((i_avs.read || i_avs.write) && state.waitreq) begin
            next_state.rdata = i_avs.read ? {24'h000000, read_byte(state, idx)} : UNMAPPED_DATA;
        end
        // low byte read latches the high byte for a coherent pair
        if (take && i_avs.read && (idx == IDX_MIR_LO || idx == IDX_CH_RES_LO)) begin
            next_state.scratch = state.result[15:8];
        end
        // conversion completion
        if (i_conv_done) begin
            next_state.result = fmt_result(i_conv_raw, res_mode, sgn_mode, diff_mode);
            if (scan_on) begin
                if (state.scan_offset == state.scan_count) begin
                    next_state.scan_offset = 4'h0;
                end else begin
                    next_state.scan_offset = state.scan_offset + 4'h1;
                end
            end
            if (state.ctrl_b[CONTINUOUS_CONVERSION_BIT] && state.ctrl_a[ENABLE_BIT]) begin
                next_state.start = 1'b1;
            end
        end
        // flag clear by service or write one; a new completion wins
        if (i_vector_ack) begin
            next_state.flag = 1'b0;
        end
        if (wr_en && (idx == IDX_FLAGS || idx == IDX_CH_FLAGS) && wbyte[FLAG_BIT]) begin
            next_state.flag = 1'b0;
        end
        if (i_conv_done) begin
            next_state.flag = 1'b1;
        end
        // register writes
        if (wr_en) begin
            if (idx == IDX_CTRL_A) begin
                next_state.ctrl_a = wbyte & ~(8'h01 << GO_BIT);
                if (wbyte[GO_BIT] && wbyte[ENABLE_BIT]) begin
                    next_state.start = 1'b1;
                end
            end else if (idx == IDX_CTRL_B) begin
                next_state.ctrl_b = wbyte;
            end else if (idx == IDX_REFCTL) begin
                next_state.refctl = wbyte;
            end else if (idx == IDX_EVCTL) begin
                next_state.evctl = wbyte;
            end else if (idx == IDX_CLKDIV) begin
                next_state.clkdiv = wbyte;
            end else if (idx == IDX_SCRATCH) begin
                next_state.scratch = wbyte;
            end else if (idx == IDX_SAMPLE) begin
                next_state.sample = wbyte;
            end else if (idx == IDX_CAL_LO) begin
                next_state.cal_lo = wbyte;
            end else if (idx == IDX_CMP_LO) begin
                next_state.cmp_lo = wbyte;
            end else if (idx == IDX_CMP_HI) begin
                next_state.cmp_hi = wbyte;
            end else if (idx == IDX_CH_CTRL) begin
                next_state.ch_ctrl = wbyte;
            end else if (idx == IDX_CH_MUX) begin
                next_state.ch_mux = wbyte & 8'h7f;
            end else if (idx == IDX_CH_INTCTL) begin
                next_state.ch_intctl = wbyte & 8'h0f;
            end else if (idx == IDX_CH_SCAN) begin
                next_state.scan_offset = wbyte[OFFSET_LSB +: 4];
                next_state.scan_count = wbyte[COUNT_LSB +: 4];
            end
        end
        // applied positive input for the coming conversion
        if (next_state.scan_count != 4'h0) begin
            next_state.pos_applied = next_state.ch_mux[POSITIVE_INPUT_SELECT_LSB +: 4]
                                     + next_state.scan_offset;
        end else begin
            next_state.pos_applied = next_state.ch_mux[POSITIVE_INPUT_SELECT_LSB +: 4];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= '0;
            state.waitreq <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign o_waitrequest = state.waitreq;
    assign o_readdata = state.rdata;
    assign o_pos_input = state.pos_applied;
    assign o_conv_start = state.start;
    assign o_flag = state.flag;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_left_high_byte: assert property (
        i_conv_done && res_mode == RES_12_LEFT |=> state.result[15:8] == $past(i_conv_raw[11:4]))
        else $error("left adjusted high byte wrong");
    a_left_low_bits: assert property (
        i_conv_done && res_mode == RES_12_LEFT
        |=> state.result[7:0] == {$past(i_conv_raw[3:0]), 4'h0})
        else $error("left adjusted low byte wrong");
    a_right_sign_ext: assert property (
        i_conv_done && res_mode == RES_12_RIGHT
        |=> state.result[15:12] == (($past(sgn_mode) && $past(diff_mode))
                                    ? {4{$past(i_conv_raw[11])}} : 4'h0))
        else $error("right adjusted sign extension wrong");
    a_right_bits: assert property (
        i_conv_done && res_mode == RES_12_RIGHT |=> state.result[11:0] == $past(i_conv_raw))
        else $error("right adjusted result bits wrong");
    a_eight_bit_ext: assert property (
        i_conv_done && res_mode == RES_8
        |=> state.result == {($past(sgn_mode) ? {8{$past(i_conv_raw[7])}} : 8'h00),
                             $past(i_conv_raw[7:0])})
        else $error("eight bit result wrong");
    a_scan_wrap: assert property (
        i_conv_done && scan_on && state.scan_offset == state.scan_count && !wr_en
        |=> state.scan_offset == 4'h0)
        else $error("offset did not wrap");
    a_scan_step: assert property (
        i_conv_done && scan_on && state.scan_offset != state.scan_count && !wr_en
        |=> state.scan_offset == $past(state.scan_offset) + 4'h1)
        else $error("offset did not step");
    a_scan_hold: assert property (
        !scan_on && !wr_en |=> $stable(state.scan_offset))
        else $error("offset moved while scan off");
    a_pos_applied: assert property (
        ##1 o_pos_input == (scan_on ? mux_pos + state.scan_offset : mux_pos))
        else $error("applied input wrong");
    a_flag_set: assert property (
        i_conv_done |=> o_flag ##1 (o_flag || $past(i_vector_ack) || $past(wr_en)))
        else $error("flag not set on completion");
    a_bus_answer: assert property (
        (i_avs.read || i_avs.write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
        else $error("bus answer timing wrong");

    // ------------------------------------------------------------
    // result format checks
    // ------------------------------------------------------------
    a_eight_low_byte: assert property (
        i_conv_done && res_mode != RES_12_LEFT
        |=> state.result[7:0] == $past(i_conv_raw[7:0]))
        else $error("result low byte wrong");
    a_sign_eight: assert property (
        i_conv_done && res_mode == RES_8 && sgn_mode
        |=> state.result[15] == $past(i_conv_raw[7]))
        else $error("eight bit sign wrong");
    a_sign_twelve: assert property (
        i_conv_done && res_mode == RES_12_RIGHT && sgn_mode && diff_mode
        |=> state.result[15] == $past(i_conv_raw[11]))
        else $error("twelve bit sign wrong");
    a_left_sign: assert property (
        i_conv_done && res_mode == RES_12_LEFT
        |=> state.result[15] == $past(i_conv_raw[11]))
        else $error("left adjusted sign wrong");
    a_right_zero_ext: assert property (
        i_conv_done && res_mode == RES_12_RIGHT && !diff_mode
        |=> state.result[15:12] == 4'h0)
        else $error("right adjusted fill not zero");
    a_eight_zero_ext: assert property (
        i_conv_done && res_mode == RES_8 && !sgn_mode
        |=> state.result[15:8] == RESET_BYTE)
        else $error("eight bit fill not zero");
    a_result_stable: assert property (
        !i_conv_done
        |=> $stable(state.result))
        else $error("result moved without conversion");
    a_low_read_only: assert property (
        wr_en && (idx == IDX_CH_RES_LO || idx == IDX_MIR_LO) && !i_conv_done
        |=> $stable(state.result))
        else $error("result low written");

    // ------------------------------------------------------------
    // bus and pairing checks
    // ------------------------------------------------------------
    a_pair_latch: assert property (
        take && i_avs.read && (idx == IDX_MIR_LO || idx == IDX_CH_RES_LO)
        |=> state.scratch == $past(state.result[15:8]))
        else $error("high byte not latched");
    a_high_latch: assert property (
        i_avs.read && o_waitrequest && (idx == IDX_MIR_HI || idx == IDX_CH_RES_HI)
        |=> o_readdata == {24'h000000, $past(state.scratch)})
        else $error("high byte read wrong");
    a_mirror_low: assert property (
        i_avs.read && o_waitrequest && (idx == IDX_MIR_LO || idx == IDX_CH_RES_LO)
        |=> o_readdata == {24'h000000, $past(state.result[7:0])})
        else $error("low byte read wrong");
    a_bus_idle: assert property (
        !(i_avs.read || i_avs.write)
        |=> o_waitrequest)
        else $error("answer without request");
    a_write_zero: assert property (
        i_avs.write && o_waitrequest
        |=> o_readdata == UNMAPPED_DATA)
        else $error("read data not zero on write");
    a_chan_ctrl: assert property (
        wr_en && idx == IDX_CH_CTRL
        |=> state.ch_ctrl == $past(wbyte))
        else $error("channel control write lost");
    a_mux_field: assert property (
        wr_en && idx == IDX_CH_MUX
        |=> mux_pos == $past(wbyte[POSITIVE_INPUT_SELECT_LSB +: 4]))
        else $error("positive selector field wrong");

    // ------------------------------------------------------------
    // flag and scan checks
    // ------------------------------------------------------------
    a_flag_read: assert property (
        i_avs.read && o_waitrequest && (idx == IDX_FLAGS || idx == IDX_CH_FLAGS)
        |=> o_readdata[FLAG_BIT] == $past(state.flag))
        else $error("flag read wrong");
    a_flag_w1c: assert property (
        wr_en && (idx == IDX_FLAGS || idx == IDX_CH_FLAGS) && wbyte[FLAG_BIT] && !i_conv_done
        |=> !o_flag)
        else $error("flag not cleared by write");
    a_flag_vector: assert property (
        i_vector_ack && !i_conv_done
        |=> !o_flag)
        else $error("flag not cleared by service");
    a_flag_hold: assert property (
        o_flag && !i_vector_ack && !wr_en
        |=> o_flag)
        else $error("flag dropped without clear");
    a_scan_write: assert property (
        wr_en && idx == IDX_CH_SCAN
        |=> {state.scan_offset, state.scan_count} == $past(wbyte))
        else $error("scan write lost");
    a_scan_off_hold: assert property (
        i_conv_done && !scan_on && !wr_en
        |=> state.scan_offset == $past(state.scan_offset) && o_pos_input == $past(mux_pos))
        else $error("scan off moved input");
    a_scan_restart: assert property (
        i_conv_done && scan_on && state.scan_offset == state.scan_count && !wr_en
        |=> o_pos_input == $past(mux_pos))
        else $error("scan did not restart at selector");
    a_scan_step_pos: assert property (
        i_conv_done && scan_on && state.scan_offset != state.scan_count && !wr_en
        |=> o_pos_input == $past(mux_pos) + $past(state.scan_offset) + 4'h1)
        else $error("scan input did not step");
    a_scan_read: assert property (
        i_avs.read && o_waitrequest && idx == IDX_CH_SCAN
        |=> o_readdata[7:0] == {$past(state.scan_offset), $past(state.scan_count)})
        else $error("scan read wrong");

    c_scan_wrap: cover property (i_conv_done && scan_on && state.scan_offset == state.scan_count);
    c_left_adjust: cover property (i_conv_done && res_mode == RES_12_LEFT);
    c_pair_read: cover property (take && i_avs.read && idx == IDX_CH_RES_LO
                                 ##[1:20] take && i_avs.read && idx == IDX_CH_RES_HI);
    c_flag_service: cover property (o_flag && i_vector_ack);
    c_eight_signed: cover property (i_conv_done && res_mode == RES_8 && sgn_mode);
endmodule
`default_nettype wire

// ===== bench/adcrf_core_test.sv
`timescale 1ns/1ns
`default_nettype none
module adcrf_core_test;
    import adcrf_pkg::*;
    logic i_clk;
    logic i_rstn;
    adcrf_avs_req_s avs;
    logic waitreq;
    logic [31:0] rdata;
    logic conv_done;
    logic [11:0] conv_raw;
    logic vec_ack;
    logic [3:0] pos_input;
    logic conv_start;
    logic flag;
    int num_errors = 0;
    int compares = 0;
    int starts = 0;
    int s0;
    logic [31:0] rd;
    logic [15:0] res16;
    logic [11:0] raw;
    logic [3:0] offs;

    adcrf_core u_dut (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_avs(avs),
        .o_waitrequest(waitreq),
        .o_readdata(rdata),
        .i_conv_done(conv_done),
        .i_conv_raw(conv_raw),
        .i_vector_ack(vec_ack),
        .o_pos_input(pos_input),
        .o_conv_start(conv_start),
        .o_flag(flag)
    );

    // ------------------------------------------------------------
    // clock, start pulse count, watchdog
    // ------------------------------------------------------------
    initial i_clk = 1'b0;
    always #5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        if (conv_start === 1'b1) begin
            starts <= starts + 1;
        end
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        $display("Error at %0t: run timeout", $time);
        final_report();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        avs.read <= ~wr;
        avs.write <= wr;
        avs.address <= {idx, 2'b00};
        avs.byteenable <= be;
        avs.writedata <= {24'h000000, wd};
        do begin
            @(posedge i_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        avs.read <= 1'b0;
        avs.write <= 1'b0;
        @(posedge i_clk);
        if (n >= 20) begin
            num_errors++;
            $display("Error at %0t: bus timeout", $time);
            final_report();
        end
    endtask

    task automatic wr8(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] q;
        bus(1'b1, idx, wd, 4'h1, q);
    endtask

    task automatic rres(input logic mirror, output logic [15:0] v);
        logic [31:0] lo;
        logic [31:0] hi;
        bus(1'b0, mirror ? IDX_MIR_LO : IDX_CH_RES_LO, 8'h00, 4'h1, lo);
        bus(1'b0, mirror ? IDX_MIR_HI : IDX_CH_RES_HI, 8'h00, 4'h1, hi);
        v = {hi[7:0], lo[7:0]};
    endtask

    task automatic conv(input logic [11:0] x);
        conv_raw <= x;
        conv_done <= 1'b1;
        @(posedge i_clk);
        conv_done <= 1'b0;
        @(posedge i_clk);
    endtask

    function automatic logic [15:0] fmt(input logic [1:0] r, input logic s, input logic d,
                                        input logic [11:0] x);
        if (r == RES_12_LEFT) begin
            return {x, 4'h0};
        end
        if (r == RES_8) begin
            return {{8{s & x[7]}}, x[7:0]};
        end
        return {{4{s & d & x[11]}}, x};
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        avs = '0;
        conv_done = 1'b0;
        conv_raw = 12'h000;
        vec_ack = 1'b0;
        i_rstn = 1'b0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        bus(1'b0, IDX_CH_RES_LO, 8'h00, 4'h1, rd);
        chk(rd, 32'h00000000, "result low reset");
        bus(1'b0, IDX_CH_SCAN, 8'h00, 4'h1, rd);
        chk(rd, 32'h00000000, "scan reset");
        bus(1'b0, 8'h05, 8'h00, 4'h1, rd);
        chk(rd, 32'h00000000, "unmapped read");
        // every resolution, signedness and input mode
        for (int m = 0; m < 16; m++) begin
            wr8(IDX_CTRL_B, {3'h0, m[2], 1'b0, m[1:0], 1'b0});
            wr8(IDX_CH_CTRL, {6'h00, m[3], 1'b0});
            for (int k = 0; k < 2; k++) begin
                raw = k[0] ? 12'h8a5 : 12'h47f;
                conv(raw);
                rres(m[0] ^ k[0], res16);
                chk({16'h0, res16}, {16'h0, fmt(m[1:0], m[2], m[3], raw)}, "result");
            end
        end
        // result read-only, refused byte lane
        wr8(IDX_CH_RES_LO, 8'hf0);
        rres(1'b0, res16);
        chk({16'h0, res16}, {16'h0, fmt(2'h3, 1'b1, 1'b1, 12'h8a5)}, "result after write");
        wr8(IDX_SCRATCH, 8'haa);
        bus(1'b1, IDX_SCRATCH, 8'h55, 4'h0, rd);
        bus(1'b0, IDX_SCRATCH, 8'h00, 4'h1, rd);
        chk(rd, 32'h000000aa, "scratch lane refused");
        // completion flag
        chk({31'h0, flag}, 32'h1, "flag set");
        bus(1'b0, IDX_CH_FLAGS, 8'h00, 4'h1, rd);
        chk(rd, 32'h00000001, "flag read");
        wr8(IDX_FLAGS, 8'h01);
        @(posedge i_clk);
        chk({31'h0, flag}, 32'h0, "flag write clear");
        conv(12'h123);
        vec_ack <= 1'b1;
        @(posedge i_clk);
        vec_ack <= 1'b0;
        @(posedge i_clk);
        chk({31'h0, flag}, 32'h0, "flag vector clear");
        // scan disabled keeps offset
        wr8(IDX_CH_MUX, 8'h70);
        wr8(IDX_CH_SCAN, 8'h20);
        conv(12'h001);
        conv(12'h002);
        bus(1'b0, IDX_CH_SCAN, 8'h00, 4'h1, rd);
        chk(rd, 32'h00000020, "scan held");
        chk({28'h0, pos_input}, 32'h0000000e, "applied input scan off");
        // scan steps and wraps
        wr8(IDX_CH_SCAN, 8'h13);
        repeat (2) @(posedge i_clk);
        offs = 4'h1;
        for (int i = 0; i < 9; i++) begin
            chk({28'h0, pos_input}, {28'h0, 4'he + offs}, "applied input");
            conv(12'h0aa);
            offs = (offs == 4'h3) ? 4'h0 : offs + 4'h1;
        end
        bus(1'b0, IDX_CH_SCAN, 8'h00, 4'h1, rd);
        chk(rd, {24'h0, offs, 4'h3}, "scan after steps");
        // conversion start, single and free running
        s0 = starts;
        wr8(IDX_CTRL_A, 8'h05);
        repeat (3) @(posedge i_clk);
        chk(32'(starts - s0), 32'h1, "start pulse");
        wr8(IDX_CTRL_B, 8'h08);
        s0 = starts;
        conv(12'h010);
        repeat (2) @(posedge i_clk);
        chk(32'(starts - s0), 32'h1, "continuous_conversion restart");
        final_report();
    end
endmodule
`default_nettype wire
